// >>> core/adcss_pkg.sv
// Constants for the converter sequence, stability and status slice.
// Assumes a 32-bit AHB-Lite bus decoded on the low address byte.
package adcss_pkg;
  localparam int          CH_N            = 16;
  localparam int          CH_W            = 4;
  localparam int          ADDR_W          = 8;
  // Register byte offsets
  localparam logic [7:0]  OFF_SEQ_DELAY   = 8'h78;
  localparam logic [7:0]  OFF_STAB        = 8'h84;
  localparam logic [7:0]  OFF_INT_SRC     = 8'h8C;
  localparam logic [7:0]  OFF_RES_FIRST   = 8'h90;
  localparam logic [7:0]  OFF_RES_LAST    = 8'hCC;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'hE0;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'hE4;
  localparam logic [7:0]  OFF_SEQ_RUN     = 8'hE8;
  // Settle delay field
  localparam int          DLY_LSB         = 0;
  localparam int          DLY_W           = 6;
  localparam int          SETTLE_UNIT     = 25;
  localparam int          SETTLE_W        = 11;
  // Stability control fields
  localparam int          THR_LSB         = 0;
  localparam int          THR_W           = 7;
  localparam int          RSTLEN_LSB      = 8;
  localparam int          RSTLEN_W        = 5;
  localparam int          OVL_FLAG_BIT    = 16;
  localparam logic [6:0]  THR_RESET       = 7'h1E;
  localparam logic [4:0]  RSTLEN_RESET    = 5'h08;
  // Combined status fields
  localparam int          INT_CCC_BIT     = 31;
  localparam int          INT_DOF_BIT     = 29;
  localparam int          INT_SE_LSB      = 0;
  // Sequence run control fields
  localparam int          RUN_START_BIT   = 0;
  localparam int          RUN_CONT_BIT    = 1;
  localparam int          RUN_INCR_BIT    = 2;
  localparam int          RUN_STOP_BIT    = 3;
  localparam int          RUN_OSR_LSB     = 8;
  localparam int          OSR_W           = 8;
  localparam logic [7:0]  OSR_RESET       = 8'h64;
  localparam int          RUN_CHEN_LSB    = 16;
  // Result word fields
  localparam int          RES_DONE_BIT    = 0;
  localparam int          RES_OVL_BIT     = 1;
  localparam int          RES_ERR_BIT     = 2;
  localparam int          RES_DATA_LSB    = 4;
  localparam int          RES_DATA_W      = 12;
  // Interrupt event bits
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_OVL         = 1;
  localparam int          IRQ_SEQEND      = 2;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef enum logic [1:0] {
    ADCSS_IDLE    = 2'h0,
    ADCSS_SETTLE  = 2'h1,
    ADCSS_CONVERT = 2'h3,
    ADCSS_ADVANCE = 2'h2
  } adcss_state_t;
endpackage

// >>> core/adcss_top.sv
// Converter control slice: settle delay sequencer, modulator stability
// monitor, per-channel result status and combined interrupt status.
// Assumes modulator clock and bitstream arrive as asynchronous pins.
//
// Local design decision: the AHB-Lite interface to the registers.
module adcss_top
  import adcss_pkg::*;
(
  input  wire logic                          clk_sys,           // System clock
  input  wire logic                          reset,             // Sync reset, high
  input  wire logic                          hsel,              // Slave select
  input  wire logic [31:0]                   haddr,             // Byte address
  input  wire logic [1:0]                    htrans,            // Transfer type
  input  wire logic                          hwrite,            // Write access
  input  wire logic [2:0]                    hsize,             // Transfer size
  input  wire logic [31:0]                   hwdata,            // Write data
  input  wire logic                          hready,            // Bus ready
  output logic                               hreadyout,         // Slave ready
  output logic      [31:0]                   hrdata,            // Read data
  output logic                               hresp,             // Always OKAY
  input  wire logic                          modClk,            // Modulator clock pin
  input  wire logic                          modBit,            // Modulator bitstream
  output logic                               integratorReset,   // Modulator reset
  output logic      [adcss_pkg::CH_N-1:0]    channelEnable,     // Active channel
  output logic                               filterAccumulate,  // Filters running
  output logic                               converterInterrupt,// Combined interrupt
  output logic                               irqOut             // Masked event irq
);
  import adcss_pkg::*;

  function automatic logic [CH_W-1:0] nextChan(input logic [CH_N-1:0] mask,
                                               input logic [CH_W-1:0] cur);
    logic [CH_W-1:0] idx;
    logic            hit;
    nextChan = cur;
    hit      = 1'b0;
    for (int i = 1; i <= CH_N; i++) begin
      idx = cur + CH_W'(i);
      if (!hit && mask[idx]) begin
        nextChan = idx;
        hit      = 1'b1;
      end
    end
  endfunction

  function automatic logic [SETTLE_W-1:0] settleTicks(input logic [DLY_W-1:0] d);
    settleTicks = SETTLE_W'(d) * SETTLE_W'(SETTLE_UNIT);
  endfunction

  function automatic logic [CH_W-1:0] resIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel      = a - OFF_RES_FIRST;
    resIndex = rel[CH_W+1:2];
  endfunction

  function automatic logic isResult(input logic [ADDR_W-1:0] a);
    isResult = (a >= OFF_RES_FIRST) && (a <= OFF_RES_LAST) && (a[1:0] == 2'h0);
  endfunction

  logic                    modClkSync1, modClkSync2, modClkSync3;
  logic                    modBitSync1, modBitSync2;
  logic                    modTick;
  logic                    dpValid, dpWrite;
  logic [ADDR_W-1:0]       dpAddr;
  logic                    addrTaken, readTaken, writeStrobe;
  logic [ADDR_W-1:0]       aAddr;
  logic [31:0]             readMux;
  logic [DLY_W-1:0]        settleDelay;
  logic [THR_W-1:0]        overloadRunThreshold;
  logic [RSTLEN_W-1:0]     overloadResetLength;
  logic [OSR_W-1:0]        oversamplingRatio;
  logic                    continuousMode, incrementalMode;
  logic [CH_N-1:0]         chanMask;
  logic                    startReq, stopReq;
  logic                    overloadFlag;
  logic                    prevBit;
  logic [THR_W:0]          runCount;
  logic [THR_W:0]          next_runCount;
  logic [RSTLEN_W-1:0]     rstCount;
  logic                    incrRst;
  logic                    sameBit, monitorOn, ovlDetect;
  adcss_state_t            state;
  logic [CH_W-1:0]         curChan, nxtChan;
  logic [SETTLE_W-1:0]     settleCnt;
  logic [OSR_W-1:0]        convCnt;
  logic [RES_DATA_W-1:0]   onesCnt;
  logic                    convOvl, convDone, convStart, seqEnd;
  logic [CH_N-1:0]         resDone, resOvl, resErr;
  logic [RES_DATA_W-1:0]   resData [CH_N];
  logic [IRQ_W-1:0]        irqStatus, irqMask, irqEvents;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modClkSync1 <= 1'b0;
      modClkSync2 <= 1'b0;
      modClkSync3 <= 1'b0;
      modBitSync1 <= 1'b0;
      modBitSync2 <= 1'b0;
    end else begin
      modClkSync1 <= modClk;
      modClkSync2 <= modClkSync1;
      modClkSync3 <= modClkSync2;
      modBitSync1 <= modBit;
      modBitSync2 <= modBitSync1;
    end
  end
  assign modTick = modClkSync2 & ~modClkSync3;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  assign aAddr       = haddr[ADDR_W-1:0];
  assign addrTaken   = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign readTaken   = addrTaken && !hwrite;
  assign writeStrobe = dpValid && dpWrite;

  always_comb begin
    readMux = 32'h0000_0000;
    if (isResult(aAddr)) begin
      readMux[RES_DONE_BIT]                       = resDone[resIndex(aAddr)];
      readMux[RES_OVL_BIT]                        = resOvl[resIndex(aAddr)];
      readMux[RES_ERR_BIT]                        = resErr[resIndex(aAddr)];
      readMux[RES_DATA_LSB +: RES_DATA_W]         = resData[resIndex(aAddr)];
    end else begin
      unique case (aAddr)
        OFF_SEQ_DELAY: readMux[DLY_LSB +: DLY_W] = settleDelay;
        OFF_STAB: begin
          readMux[THR_LSB +: THR_W]       = overloadRunThreshold;
          readMux[RSTLEN_LSB +: RSTLEN_W] = overloadResetLength;
          readMux[OVL_FLAG_BIT]           = overloadFlag;
        end
        OFF_INT_SRC: begin
          readMux[INT_CCC_BIT]            = |resDone;
          readMux[INT_DOF_BIT]            = |resOvl;
          readMux[INT_SE_LSB +: CH_N]     = resDone;
        end
        OFF_IRQ_STATUS: readMux[IRQ_W-1:0] = irqStatus;
        OFF_IRQ_MASK:   readMux[IRQ_W-1:0] = irqMask;
        OFF_SEQ_RUN: begin
          readMux[RUN_CONT_BIT]           = continuousMode;
          readMux[RUN_INCR_BIT]           = incrementalMode;
          readMux[RUN_OSR_LSB +: OSR_W]   = oversamplingRatio;
          readMux[RUN_CHEN_LSB +: CH_N]   = chanMask;
        end
        default: readMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dpValid   <= 1'b0;
      dpWrite   <= 1'b0;
      dpAddr    <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      dpValid   <= addrTaken;
      dpWrite   <= hwrite;
      dpAddr    <= aAddr;
      hrdata    <= readTaken ? readMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      settleDelay          <= '0;
      overloadRunThreshold <= THR_RESET;
      overloadResetLength  <= RSTLEN_RESET;
      oversamplingRatio    <= OSR_RESET;
      continuousMode       <= 1'b0;
      incrementalMode      <= 1'b0;
      chanMask             <= '0;
      irqMask              <= '0;
      startReq             <= 1'b0;
      stopReq              <= 1'b0;
    end else begin
      startReq <= 1'b0;
      stopReq  <= 1'b0;
      if (writeStrobe) begin
        unique case (dpAddr)
          OFF_SEQ_DELAY: settleDelay <= hwdata[DLY_LSB +: DLY_W];
          OFF_STAB: begin
            overloadRunThreshold <= hwdata[THR_LSB +: THR_W];
            overloadResetLength  <= hwdata[RSTLEN_LSB +: RSTLEN_W];
          end
          OFF_IRQ_MASK: irqMask <= hwdata[IRQ_W-1:0];
          OFF_SEQ_RUN: begin
            continuousMode    <= hwdata[RUN_CONT_BIT];
            incrementalMode   <= hwdata[RUN_INCR_BIT];
            oversamplingRatio <= hwdata[RUN_OSR_LSB +: OSR_W];
            chanMask          <= hwdata[RUN_CHEN_LSB +: CH_N];
            startReq          <= hwdata[RUN_START_BIT];
            stopReq           <= hwdata[RUN_STOP_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stability monitor
  assign monitorOn     = (overloadResetLength != '0);
  assign sameBit       = (modBitSync2 == prevBit);
  assign next_runCount = sameBit ? ((&runCount) ? runCount : runCount + 1'b1)
                                 : '0;
  assign ovlDetect     = modTick && monitorOn && (rstCount == '0) && sameBit
                      && (next_runCount >= {1'b0, overloadRunThreshold});

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prevBit  <= 1'b0;
      runCount <= '0;
      rstCount <= '0;
    end else if (modTick) begin
      prevBit <= modBitSync2;
      if (ovlDetect) begin
        runCount <= '0;
        rstCount <= overloadResetLength;
      end else if (!monitorOn || rstCount != '0) begin
        runCount <= '0;
        rstCount <= monitorOn ? rstCount - 1'b1 : '0;
      end else begin
        runCount <= next_runCount;
      end
    end
  end

  // Incremental mode adds a one-tick reset at each conversion start
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      incrRst         <= 1'b0;
      integratorReset <= 1'b0;
    end else begin
      if (convStart && incrementalMode) begin
        incrRst <= 1'b1;
      end else if (modTick) begin
        incrRst <= 1'b0;
      end
      integratorReset <= (rstCount != '0) || incrRst;
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overloadFlag <= 1'b0;
    end else if (ovlDetect) begin
      overloadFlag <= 1'b1;
    end else if (readTaken && aAddr == OFF_STAB) begin
      overloadFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel sequencer
  assign nxtChan   = nextChan(chanMask, curChan);
  assign convDone  = (state == ADCSS_CONVERT) && modTick
                  && (convCnt + 1'b1 >= oversamplingRatio);
  assign convStart = (state == ADCSS_SETTLE) && (settleCnt == '0);
  assign seqEnd    = (state == ADCSS_ADVANCE) && !continuousMode && (nxtChan <= curChan);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state            <= ADCSS_IDLE;
      curChan          <= '0;
      settleCnt        <= '0;
      convCnt          <= '0;
      onesCnt          <= '0;
      convOvl          <= 1'b0;
      channelEnable    <= '0;
      filterAccumulate <= 1'b0;
    end else if (stopReq) begin
      state            <= ADCSS_IDLE;
      channelEnable    <= '0;
      filterAccumulate <= 1'b0;
    end else begin
      unique case (state)
        ADCSS_IDLE: begin
          if (startReq && chanMask != '0) begin
            curChan       <= nextChan(chanMask, {CH_W{1'b1}});
            channelEnable <= CH_N'(1) << nextChan(chanMask, {CH_W{1'b1}});
            settleCnt     <= settleTicks(settleDelay);
            state         <= ADCSS_SETTLE;
          end
        end
        ADCSS_SETTLE: begin
          if (settleCnt == '0) begin
            convCnt          <= '0;
            onesCnt          <= '0;
            convOvl          <= 1'b0;
            filterAccumulate <= 1'b1;
            state            <= ADCSS_CONVERT;
          end else if (modTick) begin
            settleCnt <= settleCnt - 1'b1;
          end
        end
        ADCSS_CONVERT: begin
          // Overload reset leaves the oversampling count running
          if (ovlDetect) begin
            convOvl <= 1'b1;
          end
          if (modTick) begin
            convCnt <= convCnt + 1'b1;
            onesCnt <= onesCnt + RES_DATA_W'(modBitSync2);
          end
          if (convDone) begin
            filterAccumulate <= 1'b0;
            state            <= ADCSS_ADVANCE;
          end
        end
        ADCSS_ADVANCE: begin
          if (seqEnd) begin
            channelEnable <= '0;
            state         <= ADCSS_IDLE;
          end else begin
            curChan       <= nxtChan;
            channelEnable <= CH_N'(1) << nxtChan;
            settleCnt     <= settleTicks(settleDelay);
            state         <= ADCSS_SETTLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result status, cleared by reading the channel's result word
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      resDone <= '0;
      resOvl  <= '0;
      resErr  <= '0;
      for (int i = 0; i < CH_N; i++) begin
        resData[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (convDone && curChan == CH_W'(i)) begin
          resDone[i] <= 1'b1;
          resOvl[i]  <= convOvl || ovlDetect;
          resErr[i]  <= convOvl || ovlDetect;
          resData[i] <= onesCnt + RES_DATA_W'(modBitSync2);
        end else if (readTaken && isResult(aAddr) && resIndex(aAddr) == CH_W'(i)) begin
          resDone[i] <= 1'b0;
          resOvl[i]  <= 1'b0;
          resErr[i]  <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts
  always_comb begin
    irqEvents             = '0;
    irqEvents[IRQ_DONE]   = convDone;
    irqEvents[IRQ_OVL]    = ovlDetect;
    irqEvents[IRQ_SEQEND] = seqEnd;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStatus <= '0;
    end else if (writeStrobe && dpAddr == OFF_IRQ_STATUS) begin
      irqStatus <= (irqStatus & ~hwdata[IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqOut             <= 1'b0;
      converterInterrupt <= 1'b0;
    end else begin
      irqOut <= |(irqStatus & irqMask);
      if (convDone) begin
        converterInterrupt <= 1'b1;
      end else if (readTaken && aAddr == OFF_INT_SRC) begin
        converterInterrupt <= 1'b0;
      end
    end
  end

endmodule // adcss_top

// >>> verif/adcss_asserts.sv
// Checker for adcss_top, bound to it at the foot of this file.
// Assumes a one-slave bus; incremental resets last under one tick.
module adcss_asserts
  import adcss_pkg::*;
(
  input wire logic            clk_sys,           // Clock
  input wire logic            reset,             // Reset
  input wire logic            hsel,              // Select
  input wire logic [31:0]     haddr,             // Address
  input wire logic [1:0]      htrans,            // Transfer
  input wire logic            hwrite,            // Write
  input wire logic [31:0]     hwdata,            // Wdata
  input wire logic            hready,            // Ready
  input wire logic            modClk,            // Mod clock
  input wire logic            integratorReset,   // Mod reset
  input wire logic [CH_N-1:0] channelEnable,     // Channel
  input wire logic            filterAccumulate,  // Filters
  input wire logic            converterInterrupt // Irq
);
  logic       wrPend;
  logic [7:0] wrAddr;
  logic [5:0] dly;
  logic [4:0] len;
  logic       clkOld;
  logic [5:0] ticks;
  wire logic  taken = hsel && hready && htrans == HTRANS_NONSEQ;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////
  // Shadow of the delay and reset length fields
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPend <= 1'b0;
      dly    <= 6'h0;
      len    <= RSTLEN_RESET;
    end else begin
      wrPend <= taken && hwrite;
      if (wrPend && wrAddr == OFF_SEQ_DELAY) dly <= hwdata[5:0];
      if (wrPend && wrAddr == OFF_STAB) len <= hwdata[12:8];
    end
  end

  // Modulator ticks seen during one reset pulse
  always_ff @(posedge clk_sys) begin
    if (taken) wrAddr <= haddr[7:0];
    clkOld <= modClk;
    ticks  <= integratorReset ? ticks + 6'(modClk && !clkOld) : 6'h0;
  end

  ////////////////////////////////////////////////////////////
  a_settle_wait: assert property (
    $changed(channelEnable) && channelEnable != '0 && dly != 6'h0 |=> !filterAccumulate [*8])
    else $error("accumulation inside settle delay");
  a_zero_delay: assert property (
    $changed(channelEnable) && channelEnable != '0 && dly == 6'h0 |-> ##[1:3] filterAccumulate)
    else $error("zero delay still waits");
  a_accum_chan: assert property (
    filterAccumulate |-> $onehot(channelEnable))
    else $error("accumulating with no channel");
  a_chan_onehot: assert property ($onehot0(channelEnable))
    else $error("several channels enabled");
  a_reset_len: assert property (
    integratorReset |-> ticks <= {1'b0, len} + 6'h2)
    else $error("integrator reset too long");
  a_monitor_off: assert property (
    len == 5'h0 && !integratorReset |=> !integratorReset)
    else $error("reset issued with monitor off");
  a_filter_kept: assert property (
    $rose(integratorReset) && $past(filterAccumulate) |-> filterAccumulate)
    else $error("overload stopped the filters");
  a_read_drops: assert property (
    taken && !hwrite && haddr[7:0] == OFF_INT_SRC && channelEnable == '0
      && !filterAccumulate |=> !converterInterrupt)
    else $error("interrupt kept after status read");
endmodule // adcss_asserts

bind adcss_top adcss_asserts u_asserts (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .modClk(modClk),
  .integratorReset(integratorReset), .channelEnable(channelEnable),
  .filterAccumulate(filterAccumulate), .converterInterrupt(converterInterrupt));

// >>> verif/adcss_modulator.sv
// Modulator model: free-running clock, 8 clk_sys cycles a period.
// Assumes clk_sys from the bench; bit moves on the falling edge.
module adcss_modulator (
  input  wire logic       clk_sys, // Clock
  input  wire logic [1:0] pattern, // 0 alt, 1 stuck, 2 random
  output logic            modClk,  // Mod clock
  output logic            modBit   // Bitstream
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;

  initial begin
    modClk = 1'b0;
    modBit = 1'b0;
  end

  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      modClk <= ~modClk;
      if (modClk) begin
        modBit <= pattern == 2'h0 ? ~modBit : pattern == 2'h1 ? 1'b1 : 1'($urandom);
      end
    end
  end
endmodule // adcss_modulator

// >>> verif/adcss_top_tb.sv
// Bench for adcss_top with modulator model and a status reference.
// Assumes adcss_pkg, the checker and the model compile first.
module adcss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adcss_pkg::*;

  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic [1:0]  pattern = 2'h0;
  logic [31:0] hrdata, d;
  logic [15:0] chanEn, lastEn;
  wire logic   hready;
  logic        hresp, modClk, modBit, intRst, acc, convIrq, irqOut;
  int          num_errors, compares, cyc, k, expDone[16], expOvl[16], order[$];

  adcss_top dut (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .modClk(modClk),
    .modBit(modBit), .integratorReset(intRst), .channelEnable(chanEn),
    .filterAccumulate(acc), .converterInterrupt(convIrq), .irqOut(irqOut));
  adcss_modulator u_mod (.clk_sys(clk_sys), .pattern(pattern), .modClk(modClk),
    .modBit(modBit));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(d, e);
    check(32'(hresp), 32'h0);
  endtask

  // Reference of the combined status word
  function automatic logic [31:0] exp_stat();
    logic [31:0] s = 32'h0;
    for (int c = 0; c < CH_N; c++) begin
      s[c] = expDone[c] != 0;
      s[INT_DOF_BIT] |= expOvl[c] != 0;
    end
    s[INT_CCC_BIT] = |s[15:0];
    return s;
  endfunction

  // One sequence; one modulator tick is 8 cycles
  task automatic run_seq(input logic [15:0] mk, input logic [7:0] oversampling_ratio, input int dly);
    logic [15:0] prev = 16'h0;
    int          ch, w;
    bus(OFF_SEQ_DELAY, 1'b1, 32'(dly));
    for (int c = 0; c < CH_N; c++) if (mk[c]) order.push_back(c);
    bus(OFF_SEQ_RUN, 1'b1, {mk, oversampling_ratio, 8'h01});
    while (order.size() > 0) begin
      ch = order.pop_front();
      while (chanEn === prev || chanEn === 16'h0) @(posedge clk_sys);
      check({16'h0, chanEn}, 32'h1 << ch);
      prev = chanEn;
      for (w = 0; acc !== 1'b1; w++) @(posedge clk_sys);
      check(32'(w >= 200 * dly - 10 && w <= 200 * dly + 20), 32'h1);
      while (acc === 1'b1) @(posedge clk_sys);
      expDone[ch] = 1;
    end
    while (chanEn !== 16'h0) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(71205));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(OFF_SEQ_DELAY, 32'h0);
    rdc(OFF_STAB, 32'h0000081E);
    bus(OFF_INT_SRC, 1'b1, 32'hFFFFFFFF);
    rdc(OFF_INT_SRC, 32'h0);
    rdc(8'h40, 32'h0);
    $display("Test reset values done");
    pattern <= 2'h2;
    run_seq(16'($urandom) | 16'h1, 8'h04, 1 + int'($urandom % 2));
    check(32'(convIrq), 32'h1);
    rdc(OFF_INT_SRC, exp_stat());
    check(32'(convIrq), 32'h0);
    rdc(OFF_INT_SRC, exp_stat());
    for (int c = 0; c < CH_N; c++) begin
      if (expDone[c] != 0) begin
        bus(OFF_RES_FIRST + 8'(4 * c), 1'b0, 32'h0);
        check(d & 32'h7, 32'h1);
        expDone[c] = 0;
        rdc(OFF_INT_SRC, exp_stat());
      end
    end
    $display("Test channel sweep done");
    rdc(OFF_IRQ_STATUS, 32'h5);
    check(32'(irqOut), 32'h0);
    bus(OFF_IRQ_MASK, 1'b1, 32'h7);
    repeat (2) @(posedge clk_sys);
    check(32'(irqOut), 32'h1);
    bus(OFF_IRQ_STATUS, 1'b1, 32'h7);
    repeat (2) @(posedge clk_sys);
    check(32'(irqOut), 32'h0);
    rdc(OFF_IRQ_STATUS, 32'h0);
    $display("Test interrupt done");
    pattern <= 2'h0;
    run_seq(16'h0002, 8'h04, 0);
    $display("Test zero delay done");
    // Continuous and incremental: channels 0,1,0 then stop
    bus(OFF_SEQ_RUN, 1'b1, 32'h0003_0407);
    lastEn = 16'h0;
    k = 0;
    for (int n = 0; n < 3; n++) begin
      while (chanEn === lastEn || chanEn === 16'h0) begin
        @(posedge clk_sys);
        k += int'(intRst === 1'b1);
      end
      check({16'h0, chanEn}, 32'h1 << (n % 2));
      lastEn = chanEn;
    end
    check(32'(k > 0), 32'h1);
    bus(OFF_SEQ_RUN, 1'b1, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    check({16'h0, chanEn}, 32'h0);
    check(32'(acc), 32'h0);
    expDone[0] = 1;
    $display("Test continuous done");
    bus(OFF_STAB, 1'b1, 32'h00000304);
    pattern <= 2'h1;
    run_seq(16'h0008, 8'h28, 1);
    expOvl[3] = 1;
    rdc(OFF_INT_SRC, exp_stat());
    bus(OFF_RES_FIRST + 8'h0C, 1'b0, 32'h0);
    check(d & 32'h7, 32'h7);
    bus(OFF_RES_FIRST + 8'h04, 1'b0, 32'h0);
    check(d & 32'h7, 32'h1);
    while (intRst === 1'b1) @(posedge clk_sys);
    while (intRst !== 1'b1) @(posedge clk_sys);
    for (k = 0; intRst === 1'b1; k++) @(posedge clk_sys);
    check(32'(k >= 23 && k <= 25), 32'h1);
    pattern <= 2'h0;
    repeat (80) @(posedge clk_sys);
    rdc(OFF_STAB, 32'h00010304);
    rdc(OFF_STAB, 32'h00000304);
    $display("Test overload done");
    bus(OFF_STAB, 1'b1, 32'h00000004);
    pattern <= 2'h1;
    k = 0;
    repeat (400) begin
      @(posedge clk_sys);
      k += int'(intRst !== 1'b0);
    end
    check(32'(k), 32'h0);
    rdc(OFF_STAB, 32'h00000004);
    $display("Test monitor off done");
    complete_run();
  end
endmodule // adcss_top_tb
